// *** verilog/alss_host.sv ***
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - start no device writes until the device clock reports stable.
// - first write clears the link enable bit to halt the link.
// - next write clears the calibration engine enable.
// - then write the chosen link format mode.
// - write multiframe length as frames per multiframe minus one.
// - write sync source select: single-ended sync or timestamp pair.
// - write calibration settings: foreground/background and offset.
// - then set the calibration engine enable to one.
// - optionally write overrange enable after calibration is enabled.
// - start continuous SYSREF before checking it and before link start.
// - confirm SYSREF timing by auto calibration or windowing first.
// - after SYSREF passes, set the link enable bit to one.
// - write calibration trigger zero, then one, to start calibration.
module alss_host #(
  parameter int WR_TMO_CYC = alss_pkg::WR_TMO_DEF
) (
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire alss_pkg::alss_sw_req_t sw_req,
  output logic [31:0]                sw_rdata,
  input  wire logic                  dev_clk_stable,
  output logic                       dev_wr_valid,
  output alss_pkg::alss_dev_wr_t     dev_wr,
  input  wire logic                  dev_wr_done,
  output logic                       sysref_run_en,
  output logic                       sysref_chk_req,
  output logic                       sysref_chk_win,
  input  wire logic                  sysref_chk_done,
  input  wire logic                  sysref_chk_ok,
  input  wire logic                  sync_req_n
);

  typedef struct packed {
    alss_pkg::alss_state_t  st;
    logic                   wr_valid;
    alss_pkg::alss_dev_wr_t wr;
    logic [15:0]            tmo;
    logic                   sr_en;
    logic                   chk_req;
    logic                   busy;
    logic                   done;
    logic                   err;
    logic                   link_on;
    alss_pkg::alss_cfg_t    cfg;
    logic [31:0]            rdata;
  } alss_host_state_t;

  localparam logic [15:0] TMO_LAST = 16'(WR_TMO_CYC - 1);

  alss_host_state_t s_ff;
  alss_host_state_t nxt_s;

  function automatic alss_pkg::alss_dev_wr_t cmd_for(
    input alss_pkg::alss_state_t st,
    input alss_pkg::alss_cfg_t   c
  );
    alss_pkg::alss_dev_wr_t r;
    r = '0;
    case (st)
      alss_pkg::S_LINK_OFF: r = '{alss_pkg::DEV_LINK_EN, 8'h00};
      alss_pkg::S_CAL_OFF:  r = '{alss_pkg::DEV_CAL_EN, 8'h00};
      alss_pkg::S_MODE:
        r = '{alss_pkg::DEV_MODE, {3'h0, c.mode}};
      alss_pkg::S_MFL:
        r = '{alss_pkg::DEV_MFL, {3'h0, c.multiframe_len_minus_one}};
      alss_pkg::S_SYNC:
        r = '{alss_pkg::DEV_SYNC, {7'h00, c.sync_ts}};
      alss_pkg::S_CALCFG:
        r = '{alss_pkg::DEV_CALCFG, {6'h00, c.off_cal, c.cal_bg}};
      alss_pkg::S_CAL_ON:   r = '{alss_pkg::DEV_CAL_EN, 8'h01};
      alss_pkg::S_OVR:
        r = '{alss_pkg::DEV_OVR, {7'h00, c.overrange_enable}};
      alss_pkg::S_LINK_ON:  r = '{alss_pkg::DEV_LINK_EN, 8'h01};
      alss_pkg::S_TRIG0:    r = '{alss_pkg::DEV_TRIG, 8'h00};
      alss_pkg::S_TRIG1:    r = '{alss_pkg::DEV_TRIG, 8'h01};
      default:              r = '0;
    endcase
    return r;
  endfunction

  // successor of each write state, taken once its write completes
  function automatic alss_pkg::alss_state_t next_of(
    input alss_pkg::alss_state_t st,
    input alss_pkg::alss_cfg_t   c
  );
    alss_pkg::alss_state_t r;
    r = alss_pkg::S_ERR;
    case (st)
      alss_pkg::S_LINK_OFF: r = alss_pkg::S_CAL_OFF;
      alss_pkg::S_CAL_OFF:  r = alss_pkg::S_MODE;
      alss_pkg::S_MODE:     r = alss_pkg::S_MFL;
      alss_pkg::S_MFL:      r = alss_pkg::S_SYNC;
      alss_pkg::S_SYNC:     r = alss_pkg::S_CALCFG;
      alss_pkg::S_CALCFG:   r = alss_pkg::S_CAL_ON;
      alss_pkg::S_CAL_ON:
        r = c.ovr_apply ? alss_pkg::S_OVR : alss_pkg::S_SR_ON;
      alss_pkg::S_OVR:      r = alss_pkg::S_SR_ON;
      alss_pkg::S_LINK_ON:  r = alss_pkg::S_TRIG0;
      alss_pkg::S_TRIG0:    r = alss_pkg::S_TRIG1;
      alss_pkg::S_TRIG1:    r = alss_pkg::S_IDLE;
      default:              r = alss_pkg::S_ERR;
    endcase
    return r;
  endfunction

  logic sw_cfg_wr;
  logic start;

  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.rdata = '0;
    sw_cfg_wr = sw_req.wr && !s_ff.busy;
    start = sw_cfg_wr && (sw_req.addr == alss_pkg::SW_CTRL)
            && sw_req.wdata[alss_pkg::CTRL_START];
    if (sw_cfg_wr)
    begin
      unique case (sw_req.addr)
        alss_pkg::SW_CTRL:
        begin
          nxt_s.cfg.ovr_apply = sw_req.wdata[alss_pkg::CTRL_OVR_APPLY];
          nxt_s.cfg.sr_win    = sw_req.wdata[alss_pkg::CTRL_SR_WIN];
        end
        alss_pkg::SW_MODE: nxt_s.cfg.mode = sw_req.wdata[4:0];
        alss_pkg::SW_MFL:
          nxt_s.cfg.multiframe_len_minus_one = sw_req.wdata[4:0];
        alss_pkg::SW_CFG:
        begin
          nxt_s.cfg.sync_ts = sw_req.wdata[alss_pkg::CFG_SYNC_TS];
          nxt_s.cfg.cal_bg  = sw_req.wdata[alss_pkg::CFG_CAL_BG];
          nxt_s.cfg.off_cal = sw_req.wdata[alss_pkg::CFG_OFF_CAL];
          nxt_s.cfg.overrange_enable = sw_req.wdata[alss_pkg::CFG_OVR_ON];
        end
        default: nxt_s.cfg = s_ff.cfg;
      endcase
    end
    if (sw_req.rd)
    begin
      unique case (sw_req.addr)
        alss_pkg::SW_CTRL:
          nxt_s.rdata = {29'h0, s_ff.cfg.sr_win, s_ff.cfg.ovr_apply, 1'b0};
        alss_pkg::SW_MODE: nxt_s.rdata = {27'h0, s_ff.cfg.mode};
        alss_pkg::SW_MFL:
          nxt_s.rdata = {27'h0, s_ff.cfg.multiframe_len_minus_one};
        alss_pkg::SW_CFG:
          nxt_s.rdata = {28'h0, s_ff.cfg.overrange_enable, s_ff.cfg.off_cal,
                         s_ff.cfg.cal_bg, s_ff.cfg.sync_ts};
        alss_pkg::SW_STAT:
          nxt_s.rdata = {20'h0, s_ff.st, 4'h0,
                         s_ff.link_on & sync_req_n,
                         s_ff.err, s_ff.done, s_ff.busy};
        default: nxt_s.rdata = '0;
      endcase
    end
    if (s_ff.wr_valid)
    begin
      nxt_s.tmo = s_ff.tmo + 16'h0001;
      if (dev_wr_done)
      begin
        nxt_s.wr_valid = 1'b0;
        nxt_s.st = next_of(s_ff.st, s_ff.cfg);
        if (s_ff.st == alss_pkg::S_LINK_OFF)
          nxt_s.link_on = 1'b0;
        if (s_ff.st == alss_pkg::S_LINK_ON)
          nxt_s.link_on = 1'b1;
        if (s_ff.st == alss_pkg::S_TRIG1)
        begin
          nxt_s.busy = 1'b0;
          nxt_s.done = 1'b1;
        end
      end
      else if (s_ff.tmo == TMO_LAST)
      begin
        nxt_s.wr_valid = 1'b0;
        nxt_s.st = alss_pkg::S_ERR;
      end
    end
    else
    begin
      unique case (s_ff.st)
        alss_pkg::S_IDLE:
          if (start)
          begin
            nxt_s.st    = alss_pkg::S_WAIT_CLK;
            nxt_s.busy  = 1'b1;
            nxt_s.done  = 1'b0;
            nxt_s.err   = 1'b0;
            nxt_s.sr_en = 1'b0;
          end
        alss_pkg::S_WAIT_CLK:
          if (dev_clk_stable)
            nxt_s.st = alss_pkg::S_LINK_OFF;
        alss_pkg::S_SR_ON:
        begin
          nxt_s.sr_en   = 1'b1;
          nxt_s.chk_req = 1'b1;
          nxt_s.st      = alss_pkg::S_SR_CHK;
        end
        alss_pkg::S_SR_CHK:
          if (sysref_chk_done)
          begin
            nxt_s.chk_req = 1'b0;
            nxt_s.st = sysref_chk_ok ? alss_pkg::S_LINK_ON
                                     : alss_pkg::S_ERR;
          end
        alss_pkg::S_ERR:
        begin
          nxt_s.busy = 1'b0;
          nxt_s.err  = 1'b1;
          nxt_s.st   = alss_pkg::S_IDLE;
        end
        default:
        begin
          // write state just entered: launch its single write
          nxt_s.wr_valid = 1'b1;
          nxt_s.wr  = cmd_for(s_ff.st, s_ff.cfg);
          nxt_s.tmo = '0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s_ff          <= '0;
      s_ff.cfg.mode <= alss_pkg::MODE_RST;
      s_ff.cfg.multiframe_len_minus_one <= alss_pkg::MFL_RST;
    end
    else
      s_ff <= nxt_s;
  end

  assign sw_rdata       = s_ff.rdata;
  assign dev_wr_valid   = s_ff.wr_valid;
  assign dev_wr         = s_ff.wr;
  assign sysref_run_en  = s_ff.sr_en;
  assign sysref_chk_req = s_ff.chk_req;
  assign sysref_chk_win = s_ff.cfg.sr_win;

  clk_gate_a: assert property (@(posedge core_clk)
    disable iff (rst)
    (s_ff.st == alss_pkg::S_WAIT_CLK && !dev_clk_stable)
    |=> s_ff.st == alss_pkg::S_WAIT_CLK && !dev_wr_valid)
    else $error("left clock wait without stable clock");
  link_off_a: assert property (@(posedge core_clk)
    disable iff (rst)
    (dev_wr_valid && s_ff.st == alss_pkg::S_LINK_OFF)
    |-> dev_wr.addr == alss_pkg::DEV_LINK_EN && dev_wr.data == 8'h00)
    else $error("link halt write wrong");
  cal_off_a: assert property (@(posedge core_clk)
    disable iff (rst)
    (s_ff.st == alss_pkg::S_CAL_OFF && $changed(s_ff.st))
    |-> $past(s_ff.st) == alss_pkg::S_LINK_OFF && $past(dev_wr_done))
    else $error("calibration halt out of order");
  mf_len_a: assert property (@(posedge core_clk)
    disable iff (rst)
    (dev_wr_valid && s_ff.st == alss_pkg::S_MFL)
    |-> dev_wr.addr == alss_pkg::DEV_MFL
        && dev_wr.data[4:0] == s_ff.cfg.multiframe_len_minus_one)
    else $error("multiframe length write wrong");
  cal_on_a: assert property (@(posedge core_clk)
    disable iff (rst)
    (s_ff.st == alss_pkg::S_CALCFG && dev_wr_valid && dev_wr_done)
    |=> s_ff.st == alss_pkg::S_CAL_ON ##1
        dev_wr_valid && dev_wr.data == 8'h01)
    else $error("calibration enable not after settings");
  sysref_on_a: assert property (@(posedge core_clk)
    disable iff (rst)
    (s_ff.st == alss_pkg::S_SR_CHK || s_ff.st == alss_pkg::S_LINK_ON)
    |-> sysref_run_en)
    else $error("sysref not running");
  sr_verify_a: assert property (@(posedge core_clk)
    disable iff (rst)
    (s_ff.st == alss_pkg::S_LINK_ON && $changed(s_ff.st))
    |-> $past(sysref_chk_done) && $past(sysref_chk_ok))
    else $error("link restart without sysref check");
  link_on_a: assert property (@(posedge core_clk)
    disable iff (rst)
    (dev_wr_valid && s_ff.st == alss_pkg::S_LINK_ON)
    |-> dev_wr.addr == alss_pkg::DEV_LINK_EN && dev_wr.data == 8'h01)
    else $error("link restart write wrong");
  trig_seq_a: assert property (@(posedge core_clk)
    disable iff (rst)
    (dev_wr_valid && dev_wr_done && s_ff.st == alss_pkg::S_TRIG0)
    |-> dev_wr.data == 8'h00 ##2 dev_wr_valid
        && dev_wr.addr == alss_pkg::DEV_TRIG && dev_wr.data == 8'h01)
    else $error("trigger zero then one broken");
  one_write_a: assert property (@(posedge core_clk)
    disable iff (rst)
    (dev_wr_valid && !dev_wr_done && s_ff.tmo != TMO_LAST)
    |=> dev_wr_valid && $stable(dev_wr))
    else $error("write changed before completion");
  wr_gap_a: assert property (@(posedge core_clk)
    disable iff (rst)
    (dev_wr_valid && dev_wr_done) |=> !dev_wr_valid)
    else $error("next write overlapped completion");

endmodule // alss_host
`default_nettype wire

// *** verilog/alss_pkg.sv ***
`default_nettype none
package alss_pkg;
  // software register map
  localparam logic [7:0] SW_CTRL = 8'h00;
  localparam logic [7:0] SW_MODE = 8'h04;
  localparam logic [7:0] SW_MFL  = 8'h08;
  localparam logic [7:0] SW_CFG  = 8'h0C;
  localparam logic [7:0] SW_STAT = 8'h10;
  localparam int CTRL_START     = 0;
  localparam int CTRL_OVR_APPLY = 1;
  localparam int CTRL_SR_WIN    = 2;
  localparam int CFG_SYNC_TS    = 0;
  localparam int CFG_CAL_BG     = 1;
  localparam int CFG_OFF_CAL    = 2;
  localparam int CFG_OVR_ON     = 3;
  localparam int STAT_BUSY      = 0;
  localparam int STAT_DONE      = 1;
  localparam int STAT_ERR       = 2;
  localparam int STAT_LINK_UP   = 3;
  localparam int STAT_ST_LSB    = 8;
  // device register addresses
  localparam logic [15:0] DEV_LINK_EN = 16'h0010;
  localparam logic [15:0] DEV_CAL_EN  = 16'h0011;
  localparam logic [15:0] DEV_MODE    = 16'h0012;
  localparam logic [15:0] DEV_MFL     = 16'h0013;
  localparam logic [15:0] DEV_SYNC    = 16'h0014;
  localparam logic [15:0] DEV_CALCFG  = 16'h0015;
  localparam logic [15:0] DEV_OVR     = 16'h0016;
  localparam logic [15:0] DEV_TRIG    = 16'h0017;
  // reset values and counts
  localparam logic [4:0] MODE_RST   = 5'h01;
  localparam logic [4:0] MFL_RST    = 5'h07;
  localparam int         WR_TMO_DEF = 1000;

  typedef enum logic [3:0] {
    S_IDLE     = 4'h0,
    S_WAIT_CLK = 4'h1,
    S_LINK_OFF = 4'h3,
    S_CAL_OFF  = 4'h2,
    S_MODE     = 4'h6,
    S_MFL      = 4'h7,
    S_SYNC     = 4'h5,
    S_CALCFG   = 4'h4,
    S_CAL_ON   = 4'hC,
    S_OVR      = 4'hD,
    S_SR_ON    = 4'hF,
    S_SR_CHK   = 4'hE,
    S_LINK_ON  = 4'hA,
    S_TRIG0    = 4'hB,
    S_TRIG1    = 4'h9,
    S_ERR      = 4'h8
  } alss_state_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } alss_sw_req_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
  } alss_dev_wr_t;

  typedef struct packed {
    logic [4:0] mode;
    logic [4:0] multiframe_len_minus_one;
    logic       sync_ts;
    logic       cal_bg;
    logic       off_cal;
    logic       overrange_enable;
    logic       ovr_apply;
    logic       sr_win;
  } alss_cfg_t;
endpackage
`default_nettype wire

// *** tb/alss_dev_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module alss_dev_model (
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  wire logic                   dev_wr_valid,
  input  wire alss_pkg::alss_dev_wr_t dev_wr,
  output logic                        dev_wr_done,
  input  wire logic                   sysref_run_en,
  input  wire logic                   sysref_chk_req,
  input  wire logic                   sysref_chk_win,
  output logic                        sysref_chk_done,
  output logic                        sysref_chk_ok,
  output logic                        sync_req_n,
  input  wire logic [3:0]             lat,
  input  wire logic                   mute,
  input  wire logic                   sr_ok
);
  logic [15:0] log_addr [0:63];
  logic [7:0]  log_data [0:63];
  int          log_cnt;
  logic        order_bad;
  logic        win_seen;
  logic        link_en_ff;
  logic [3:0]  wait_cnt;
  logic [3:0]  sr_cnt;

  always_ff @(posedge core_clk)
  begin
    dev_wr_done <= 1'b0;
    sysref_chk_done <= 1'b0;
    // qualifier is meaningless outside done
    sysref_chk_ok <= ~sysref_chk_ok;
    if (rst)
    begin
      wait_cnt <= 4'h0;
      sr_cnt <= 4'h0;
      link_en_ff <= 1'b0;
      sysref_chk_ok <= 1'b0;
      log_cnt <= 0;
      order_bad <= 1'b0;
      win_seen <= 1'b0;
    end
    else
    begin
      if (dev_wr_valid && !dev_wr_done && !mute)
      begin
        if (wait_cnt == lat)
        begin
          dev_wr_done <= 1'b1;
          wait_cnt <= 4'h0;
          log_addr[log_cnt] <= dev_wr.addr;
          log_data[log_cnt] <= dev_wr.data;
          log_cnt <= log_cnt + 1;
          if (dev_wr.addr == alss_pkg::DEV_LINK_EN)
          begin
            link_en_ff <= dev_wr.data[0];
            if (dev_wr.data[0] && !sysref_run_en)
              order_bad <= 1'b1;
          end
        end
        else
          wait_cnt <= wait_cnt + 4'h1;
      end
      if (sysref_chk_req && !sysref_chk_done)
      begin
        if (!sysref_run_en)
          order_bad <= 1'b1;
        win_seen <= sysref_chk_win;
        if (sr_cnt == lat)
        begin
          sysref_chk_done <= 1'b1;
          sysref_chk_ok <= sr_ok;
          sr_cnt <= 4'h0;
        end
        else
          sr_cnt <= sr_cnt + 4'h1;
      end
    end
  end

  // active-low sync request held until the link is enabled
  assign sync_req_n = link_en_ff;
endmodule // alss_dev_model
`default_nettype wire

// *** tb/alss_host_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module alss_host_tb;
  logic core_clk, rst, dev_clk_stable, dev_wr_valid, dev_wr_done;
  logic sysref_run_en, sysref_chk_req, sysref_chk_win, sysref_chk_done;
  logic sysref_chk_ok, sync_req_n, mute, sr_ok;
  logic [3:0] lat;
  logic [31:0] sw_rdata, rd;
  alss_pkg::alss_sw_req_t sw_req;
  alss_pkg::alss_dev_wr_t dev_wr;
  int error_cnt, samples_checked, cyc, base;
  logic [15:0] exp_addr [$];
  logic [7:0] exp_data [$];

  alss_host #(.WR_TMO_CYC(8)) i_dut (.core_clk(core_clk), .rst(rst),
    .sw_req(sw_req), .sw_rdata(sw_rdata), .dev_clk_stable(dev_clk_stable),
    .dev_wr_valid(dev_wr_valid), .dev_wr(dev_wr), .dev_wr_done(dev_wr_done),
    .sysref_run_en(sysref_run_en), .sysref_chk_req(sysref_chk_req),
    .sysref_chk_win(sysref_chk_win), .sysref_chk_done(sysref_chk_done),
    .sysref_chk_ok(sysref_chk_ok), .sync_req_n(sync_req_n));
  alss_dev_model i_dev (.core_clk(core_clk), .rst(rst),
    .dev_wr_valid(dev_wr_valid), .dev_wr(dev_wr), .dev_wr_done(dev_wr_done),
    .sysref_run_en(sysref_run_en), .sysref_chk_req(sysref_chk_req),
    .sysref_chk_win(sysref_chk_win), .sysref_chk_done(sysref_chk_done),
    .sysref_chk_ok(sysref_chk_ok), .sync_req_n(sync_req_n), .lat(lat),
    .mute(mute), .sr_ok(sr_ok));

  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic sw_wr(logic [7:0] a, logic [31:0] d);
    @(posedge core_clk) sw_req <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk) sw_req.wr <= 1'b0;
  endtask

  task automatic sw_rd(logic [7:0] a);
    @(posedge core_clk) sw_req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge core_clk) sw_req.rd <= 1'b0;
    @(negedge core_clk) rd = sw_rdata;
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    do
    begin
      sw_rd(alss_pkg::SW_STAT);
      n++;
    end
    while (rd[alss_pkg::STAT_BUSY] !== 1'b0 && n < 300);
  endtask

  task automatic ex(logic [15:0] a, logic [7:0] d);
    exp_addr.push_back(a);
    exp_data.push_back(d);
  endtask

  task automatic chk_log();
    chk("write count", exp_addr.size(), i_dev.log_cnt - base);
    foreach (exp_addr[i])
    begin
      chk("dev addr", {16'h0, exp_addr[i]}, {16'h0, i_dev.log_addr[base+i]});
      chk("dev data", {24'h0, exp_data[i]}, {24'h0, i_dev.log_data[base+i]});
    end
    exp_addr.delete();
    exp_data.delete();
  endtask

  task automatic start_seq(logic [4:0] m, logic [4:0] k, logic [3:0] c,
                           logic [2:0] ctl);
    sw_wr(alss_pkg::SW_MODE, {27'h0, m});
    sw_wr(alss_pkg::SW_MFL, {27'h0, k});
    sw_wr(alss_pkg::SW_CFG, {28'h0, c});
    base = i_dev.log_cnt;
    sw_wr(alss_pkg::SW_CTRL, {29'h0, ctl});
  endtask

  task automatic test_reset();
    sw_rd(alss_pkg::SW_MODE);
    chk("mode reset", 32'h1, rd);
    sw_rd(alss_pkg::SW_MFL);
    chk("frame length reset", 32'h7, rd);
    sw_rd(alss_pkg::SW_CFG);
    chk("cfg reset", 32'h0, rd);
    sw_rd(alss_pkg::SW_STAT);
    chk("stat reset", 32'h0, rd);
  endtask

  task automatic test_full();
    lat <= 4'h3;
    start_seq(5'h03, 5'h1F, 4'hB, 3'h7);
    sw_wr(alss_pkg::SW_MODE, 32'h1F);
    repeat (20) @(posedge core_clk);
    chk("early writes", 0, i_dev.log_cnt - base);
    dev_clk_stable <= 1'b1;
    wait_idle();
    ex(alss_pkg::DEV_LINK_EN, 8'h00);
    ex(alss_pkg::DEV_CAL_EN, 8'h00);
    ex(alss_pkg::DEV_MODE, 8'h03);
    ex(alss_pkg::DEV_MFL, 8'h1F);
    ex(alss_pkg::DEV_SYNC, 8'h01);
    ex(alss_pkg::DEV_CALCFG, 8'h01);
    ex(alss_pkg::DEV_CAL_EN, 8'h01);
    ex(alss_pkg::DEV_OVR, 8'h01);
    ex(alss_pkg::DEV_LINK_EN, 8'h01);
    ex(alss_pkg::DEV_TRIG, 8'h00);
    ex(alss_pkg::DEV_TRIG, 8'h01);
    chk_log();
    chk("sysref order", 32'h0, {31'h0, i_dev.order_bad});
    chk("sysref window", 32'h1, {31'h0, i_dev.win_seen});
    chk("run stays", 32'h1, {31'h0, sysref_run_en});
    chk("status done", 32'hA, rd);
    sw_rd(alss_pkg::SW_MODE);
    chk("busy write", 32'h3, rd);
  endtask

  task automatic test_sr_fail();
    lat <= 4'h0;
    sr_ok <= 1'b0;
    start_seq(5'h00, 5'h00, 4'h4, 3'h1);
    wait_idle();
    ex(alss_pkg::DEV_LINK_EN, 8'h00);
    ex(alss_pkg::DEV_CAL_EN, 8'h00);
    ex(alss_pkg::DEV_MODE, 8'h00);
    ex(alss_pkg::DEV_MFL, 8'h00);
    ex(alss_pkg::DEV_SYNC, 8'h00);
    ex(alss_pkg::DEV_CALCFG, 8'h02);
    ex(alss_pkg::DEV_CAL_EN, 8'h01);
    chk_log();
    chk("sysref auto", 32'h0, {31'h0, i_dev.win_seen});
    chk("status err", 32'h4, rd);
    sw_wr(alss_pkg::SW_STAT, 32'hFFFF);
    sw_rd(alss_pkg::SW_STAT);
    chk("status ro", 32'h4, rd);
    sw_rd(8'h14);
    chk("unmapped", 32'h0, rd);
    sr_ok <= 1'b1;
  endtask

  task automatic test_timeout();
    mute <= 1'b1;
    start_seq(5'h01, 5'h07, 4'h0, 3'h1);
    wait_idle();
    chk("mute writes", 0, i_dev.log_cnt - base);
    chk("status tmo", 32'h4, rd);
    chk("valid drop", 32'h0, {31'h0, dev_wr_valid});
    mute <= 1'b0;
  endtask

  task automatic finish_test();
    if (error_cnt == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      error_cnt++;
      finish_test();
    end
  end

  initial
  begin
    rst = 1'b1;
    sw_req = '0;
    dev_clk_stable = 1'b0;
    lat = 4'h0;
    mute = 1'b0;
    sr_ok = 1'b1;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    test_reset();
    test_full();
    test_sr_fail();
    test_timeout();
    finish_test();
  end
endmodule // alss_host_tb
`default_nettype wire
